// >>> src/rdt_timer.v
// one channel of the 16 bit reload down counter timer, apb slave
// assumes a 20 MHz pclk; source clocks and event pin are async
// levels; debug_mode, sleep_mode and sleep_stop_control are pclk
// domain levels from the clock generator
//
// Notes on behaviour
// - 16 bit down counter loaded from reload
// - repeat mode reloads at each underflow
// - repeat runs from run write 1 to 0
// - one-shot reloads, halts, clears run bit
// - underflow period is reload plus one ticks
// - underflow sets flag, read or write 1 clears
// - irq while flag set and enabled
// - underflow output; clock only in repeat
// - source select bits 1-0, divider 7-4
// - source 3 counts event pin rising edges
// - debug stops count unless debug run set
// - sleep freezes channel when source stops
// - preset loads reload, reads 1 meanwhile
// - run 0 stops; run reads running state
`timescale 1ns/10ps
`include "rdt_defs.vh"

module rdt_timer #(
   parameter EVENT_COUNT = 1,
   parameter DIV_W = 4,
   parameter CNT_W = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire pslverr,
   output reg [31:0] prdata,
   input wire internal_oscillator,
   input wire low_speed_crystal,
   input wire high_speed_oscillator,
   input wire external_clock_input,
   input wire event_count_input,
   input wire debug_mode,
   input wire sleep_mode,
   input wire [3:0] sleep_stop_control,
   output wire irq,
   output reg underflow_pulse,
   output reg underflow_clock
);

// ==========================================================
// registers
reg [1:0] clock_source_select;
reg [DIV_W-1:0] clock_divider_select;
reg debug_run_enable;
reg oneshot_select;
reg run_control;
reg preset_busy;
reg module_enable;
reg [CNT_W-1:0] reload_value;
reg [CNT_W-1:0] counter_value;
reg underflow_flag;
reg underflow_irq_enable;

// ==========================================================
// apb decode
wire setup_rd;
wire acc_wr;
wire acc_rd;
wire mapped;
wire wr_clock;
wire wr_mode;
wire wr_control;
wire wr_reload;
wire wr_flag;
wire wr_enable;
wire rd_flag;
wire enable_now;

// every access completes without wait states
assign pready = 1'b1;
assign mapped = (paddr == `RDT_OFS_CLOCK_CTRL) |
   (paddr == `RDT_OFS_MODE) | (paddr == `RDT_OFS_CONTROL) |
   (paddr == `RDT_OFS_RELOAD) | (paddr == `RDT_OFS_COUNTER) |
   (paddr == `RDT_OFS_IRQ_FLAG) | (paddr == `RDT_OFS_IRQ_ENABLE);
assign pslverr = psel & penable & ~mapped;
assign setup_rd = psel & ~penable & ~pwrite;
assign acc_wr = psel & penable & pwrite;
assign acc_rd = psel & penable & ~pwrite;
assign wr_clock = acc_wr & (paddr == `RDT_OFS_CLOCK_CTRL);
assign wr_mode = acc_wr & (paddr == `RDT_OFS_MODE);
assign wr_control = acc_wr & (paddr == `RDT_OFS_CONTROL);
assign wr_reload = acc_wr & (paddr == `RDT_OFS_RELOAD);
assign wr_flag = acc_wr & (paddr == `RDT_OFS_IRQ_FLAG);
assign wr_enable = acc_wr & (paddr == `RDT_OFS_IRQ_ENABLE);
assign rd_flag = acc_rd & (paddr == `RDT_OFS_IRQ_FLAG);
// enable already set or written in the same access
assign enable_now = module_enable |
   (wr_control & pwdata[`RDT_MODULE_ENABLE_BIT]);

// ==========================================================
// source clocks and event pin
wire [3:0] src_rise;
wire event_rise;
wire [3:0] src_raw;
wire src_tick;
wire is_event;
wire stalled;
wire count_tick;

// source index 0 to 3 in select order
assign src_raw = {external_clock_input, high_speed_oscillator,
   low_speed_crystal, internal_oscillator};

genvar gi;
generate
   for (gi = 0; gi < 4; gi = gi + 1) begin : g_src
      rdt_sync u_sync (
         .pclk(pclk),
         .presetn(presetn),
         .async_in(src_raw[gi]),
         .level(),
         .rise(src_rise[gi])
      );
   end
endgenerate

rdt_sync u_event_sync (
   .pclk(pclk),
   .presetn(presetn),
   .async_in(event_count_input),
   .level(),
   .rise(event_rise)
);

// source 3 is the event pin on event counting channels
assign is_event = (EVENT_COUNT != 0) &
   (clock_source_select == `RDT_SRC_EVENT);
assign src_tick = is_event ? event_rise :
   src_rise[clock_source_select];
// debug and sleep freeze the channel with state intact
assign stalled = (debug_mode & ~debug_run_enable) |
   (sleep_mode & sleep_stop_control[clock_source_select]);

rdt_clk_div #(
   .DIV_W(DIV_W),
   .CNT_W(15)
) u_div (
   .pclk(pclk),
   .presetn(presetn),
   .enable(module_enable & ~stalled),
   .bypass(is_event),
   .src_tick(src_tick),
   .div_select(clock_divider_select),
   .tick(count_tick)
);

// ==========================================================
// counter
wire underflow;

// counter passes zero: period is reload plus one ticks
assign underflow = count_tick & run_control &
   (counter_value == `RDT_COUNT_ZERO);

// preset load wins over an underflow reload
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      counter_value <= `RDT_COUNTER_RST;
      preset_busy <= 1'b0;
      run_control <= 1'b0;
   end else begin
      if (preset_busy) begin
         counter_value <= reload_value;
      end else if (underflow) begin
         counter_value <= reload_value;
      end else if (count_tick & run_control) begin
         counter_value <= counter_value - 1'b1;
      end
      if (preset_busy) begin
         preset_busy <= 1'b0;
      end else if (wr_control & pwdata[`RDT_PRESET_BIT] & enable_now) begin
         preset_busy <= 1'b1;
      end
      if (wr_control) begin
         run_control <= pwdata[`RDT_RUN_BIT] & enable_now;
      end else if (underflow & oneshot_select) begin
         run_control <= 1'b0;
      end
   end
end

// ==========================================================
// configuration registers
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      clock_source_select <= 2'h0;
      clock_divider_select <= {DIV_W{1'b0}};
      debug_run_enable <= 1'b0;
      oneshot_select <= 1'b0;
      module_enable <= 1'b0;
      reload_value <= `RDT_RELOAD_RST;
      underflow_irq_enable <= 1'b0;
   end else begin
      if (wr_clock) begin
         clock_source_select <= pwdata[`RDT_SRC_MSB:`RDT_SRC_LSB];
         clock_divider_select <= pwdata[`RDT_DIV_MSB:`RDT_DIV_LSB];
         debug_run_enable <= pwdata[`RDT_DEBUG_RUN_ENABLE_BIT];
      end
      if (wr_mode) begin
         oneshot_select <= pwdata[`RDT_ONESHOT_BIT];
      end
      if (wr_control) begin
         module_enable <= pwdata[`RDT_MODULE_ENABLE_BIT];
      end
      if (wr_reload) begin
         reload_value <= pwdata[CNT_W-1:0];
      end
      if (wr_enable) begin
         underflow_irq_enable <= pwdata[`RDT_UNDERFLOW_IRQ_ENABLE_BIT];
      end
   end
end

// ==========================================================
// flag, interrupt and underflow outputs
assign irq = underflow_flag & underflow_irq_enable;

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      underflow_flag <= 1'b0;
      underflow_pulse <= 1'b0;
      underflow_clock <= 1'b0;
   end else begin
      // set wins over a clear in the same cycle
      if (underflow) begin
         underflow_flag <= 1'b1;
      end else if (rd_flag |
         (wr_flag & pwdata[`RDT_UNDERFLOW_FLAG_BIT])) begin
         underflow_flag <= 1'b0;
      end
      underflow_pulse <= underflow;
      if (underflow & ~oneshot_select) begin
         underflow_clock <= ~underflow_clock;
      end
   end
end

// ==========================================================
// read data captured in the setup cycle
reg [31:0] next_prdata;

always @* begin
   next_prdata = 32'h00000000;
   case (paddr)
      `RDT_OFS_CLOCK_CTRL: begin
         next_prdata[`RDT_SRC_MSB:`RDT_SRC_LSB] = clock_source_select;
         next_prdata[`RDT_DIV_MSB:`RDT_DIV_LSB] = clock_divider_select;
         next_prdata[`RDT_DEBUG_RUN_ENABLE_BIT] = debug_run_enable;
      end
      `RDT_OFS_MODE: begin
         next_prdata[`RDT_ONESHOT_BIT] = oneshot_select;
      end
      `RDT_OFS_CONTROL: begin
         next_prdata[`RDT_RUN_BIT] = run_control;
         next_prdata[`RDT_PRESET_BIT] = preset_busy;
         next_prdata[`RDT_MODULE_ENABLE_BIT] = module_enable;
      end
      `RDT_OFS_RELOAD: begin
         next_prdata[CNT_W-1:0] = reload_value;
      end
      `RDT_OFS_COUNTER: begin
         next_prdata[CNT_W-1:0] = counter_value;
      end
      `RDT_OFS_IRQ_FLAG: begin
         next_prdata[`RDT_UNDERFLOW_FLAG_BIT] = underflow_flag;
      end
      `RDT_OFS_IRQ_ENABLE: begin
         next_prdata[`RDT_UNDERFLOW_IRQ_ENABLE_BIT] = underflow_irq_enable;
      end
      default: begin
         next_prdata = 32'h00000000;
      end
   endcase
end

// prdata holds until the next read setup
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      prdata <= 32'h00000000;
   end else if (setup_rd) begin
      prdata <= next_prdata;
   end
end

endmodule // rdt_timer

// >>> src/rdt_defs.vh
// constants for the reload down counter timer channel
// assumes inclusion by rdt_timer, the only design file of the channel that uses it
`ifndef RDT_DEFS_VH
`define RDT_DEFS_VH

// ==========================================================
// register byte offsets
`define RDT_OFS_CLOCK_CTRL 12'h000
`define RDT_OFS_MODE 12'h004
`define RDT_OFS_CONTROL 12'h008
`define RDT_OFS_RELOAD 12'h00C
`define RDT_OFS_COUNTER 12'h010
`define RDT_OFS_IRQ_FLAG 12'h014
`define RDT_OFS_IRQ_ENABLE 12'h018

// ==========================================================
// field positions
`define RDT_SRC_LO 1
`define RDT_SRC_HI 0
`define RDT_SRC_MSB 1
`define RDT_SRC_LSB 0
`define RDT_DIV_MSB 7
`define RDT_DIV_LSB 4
`define RDT_DEBUG_RUN_ENABLE_BIT 8
`define RDT_ONESHOT_BIT 0
`define RDT_RUN_BIT 8
`define RDT_PRESET_BIT 1
`define RDT_MODULE_ENABLE_BIT 0
`define RDT_UNDERFLOW_FLAG_BIT 0
`define RDT_UNDERFLOW_IRQ_ENABLE_BIT 0

// ==========================================================
// reset values and codes
`define RDT_RELOAD_RST 16'hFFFF
`define RDT_COUNTER_RST 16'hFFFF
`define RDT_SRC_EVENT 2'h3
`define RDT_COUNT_ZERO 16'h0000

`endif

// >>> src/rdt_sync.v
// three stage synchroniser with edge pulse for one outside level
// assumes an asynchronous level input and the pclk domain
`timescale 1ns/10ps

module rdt_sync (
   input wire pclk,
   input wire presetn,
   input wire async_in,
   output reg level,
   output reg rise
);

reg stage1;
reg stage2;
reg stage3;

// ==========================================================
// a change counts once stage 2 and stage 3 agree
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
   end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      rise <= 1'b0;
      if (stage2 == stage3) begin
         level <= stage3;
         rise <= stage3 & ~level;
      end
   end
end

endmodule // rdt_sync

// >>> src/rdt_clk_div.v
// power of two divider of source edges into counter ticks
// assumes src_tick is a one cycle pulse in the pclk domain
`timescale 1ns/10ps

module rdt_clk_div #(
   parameter DIV_W = 4,
   parameter CNT_W = 15
) (
   input wire pclk,
   input wire presetn,
   input wire enable,
   input wire bypass,
   input wire src_tick,
   input wire [DIV_W-1:0] div_select,
   output wire tick
);

reg [CNT_W-1:0] prescale;
wire [CNT_W:0] ones_mask;

// ==========================================================
// ratio is one over two to the power of div_select
assign ones_mask = ({{CNT_W{1'b0}}, 1'b1} << div_select) - 1'b1;
assign tick = enable & src_tick &
   (bypass | ((prescale & ones_mask[CNT_W-1:0]) == ones_mask[CNT_W-1:0]));

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      prescale <= {CNT_W{1'b0}};
   end else if (enable & src_tick) begin
      prescale <= prescale + 1'b1;
   end
end

endmodule // rdt_clk_div

// >>> bench/rdt_timer_checker.sv
// port assertions for the timer channel, bound into rdt_timer
// assumes one pclk domain and an apb master on the bus
`timescale 1ns/10ps

module rdt_timer_checker (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pslverr,
   input wire [31:0] prdata,
   input wire irq,
   input wire underflow_pulse,
   input wire underflow_clock
);
   // ==========================================
   // shadows of bus writes
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire fl_acc = acc && paddr == 12'h014;
   wire ie_wr = wr && paddr == 12'h018;
   reg ie;
   reg men;
   reg osm;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ie <= 1'h0;
         men <= 1'h0;
         osm <= 1'h0;
      end else begin
         if (ie_wr)
            ie <= pwdata[0];
         if (wr && paddr == 12'h008)
            men <= pwdata[0];
         if (wr && paddr == 12'h004)
            osm <= pwdata[0];
      end
   end
   // ==========================================
   // assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_err_unmapped: assert property (
      paddr[1:0] == 2'h0 |-> pslverr == (acc && paddr > 12'h018))
      else $error("pslverr does not match the address map");
   a_rdata_hold: assert property (
      !$past(psel && !penable && !pwrite) |-> $stable(prdata))
      else $error("prdata changed outside a read setup");
   a_irq_enable: assert property (irq |-> ie)
      else $error("irq high with interrupt disabled");
   a_irq_set: assert property (
      underflow_pulse && ie && !$past(fl_acc) |-> irq)
      else $error("underflow did not raise the flag");
   a_irq_rise: assert property (
      $rose(irq) && !$past(ie_wr) |-> ##[0:1] underflow_pulse)
      else $error("irq rose without an underflow");
   a_irq_fall: assert property (
      $fell(irq) |-> $past(fl_acc || ie_wr))
      else $error("irq fell without a clear");
   a_pulse_single: assert property (
      underflow_pulse |=> !underflow_pulse)
      else $error("underflow pulse longer than one cycle");
   a_pulse_module_enable: assert property (
      underflow_pulse |-> $past(men))
      else $error("underflow with module disabled");
   a_uclk_pulse: assert property (
      $changed(underflow_clock) |->
      $past(underflow_pulse) or ##[0:1] underflow_pulse)
      else $error("underflow clock moved without underflow");
   a_uclk_repeat: assert property (
      $changed(underflow_clock) |-> !$past(osm))
      else $error("underflow clock toggled in one-shot mode");
   c_repeat: cover property (underflow_pulse && !osm);
   c_oneshot: cover property (underflow_pulse && osm);
   c_irq: cover property ($rose(irq));
endmodule // rdt_timer_checker

bind rdt_timer rdt_timer_checker u_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pslverr, .prdata, .irq,
   .underflow_pulse, .underflow_clock);

// >>> bench/tb.sv
// self checking bench for the reload down counter timer channel
// assumes rdt_timer with its bound checker; sources made from pclk
`timescale 1ns/10ps

module tb;
   reg pclk = 1'h0;
   reg presetn = 1'h0;
   reg psel = 1'h0;
   reg penable = 1'h0;
   reg pwrite = 1'h0;
   reg [11:0] paddr = 12'h0;
   reg [31:0] pwdata = 32'h0;
   reg [3:0] src = 4'h0;
   reg [7:0] sc = 8'h0;
   reg evt = 1'h0;
   reg dbg = 1'h0;
   reg slp = 1'h0;
   reg [31:0] rd;
   reg err;
   reg u;
   reg [3:0] ssc = 4'h1;
   wire pready;
   wire pslverr;
   wire irq;
   wire upul;
   wire uclk;
   wire [31:0] prdata;
   integer error_cnt = 0;
   integer check_count = 0;
   integer seed = 32'hbfc2;
   integer cyc = 0;
   integer npul = 0;
   integer i, r, t0, t1, c;

   rdt_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .internal_oscillator(src[0]),
      .low_speed_crystal(src[1]), .high_speed_oscillator(src[2]),
      .external_clock_input(src[3]), .event_count_input(evt),
      .debug_mode(dbg), .sleep_mode(slp), .sleep_stop_control(ssc),
      .irq(irq), .underflow_pulse(upul), .underflow_clock(uclk));

   // ==========================================
   // clock, slow sources, timeout, pulse count
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      sc <= sc + 8'h1;
      src <= {sc[2], sc[2], sc[3], sc[2]};
      cyc = cyc + 1;
      if (cyc > 20000) begin
         error_cnt = error_cnt + 1;
         final_report;
      end
   end
   always @(negedge pclk)
      if (upul === 1'h1)
         npul = npul + 1;

   // ==========================================
   // bus and compare tasks
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'h1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'h1;
         @(posedge pclk);
         while (pready !== 1'h1)
            @(posedge pclk);
         rd = prdata;
         err = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
         @(posedge pclk);
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("Error %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task rdchk(input [11:0] a, input [31:0] exp);
      begin
         apb(1'h0, a, 32'h0);
         chk(rd, exp);
      end
   endtask
   task wpul(output integer t);
      integer n;
      begin
         n = npul;
         while (npul == n)
            @(posedge pclk);
         t = $time;
      end
   endtask
   task start(input [31:0] clk, input [31:0] md, input [31:0] rl);
      begin
         apb(1'h1, 12'h008, 32'h0);
         apb(1'h1, 12'h000, clk);
         apb(1'h1, 12'h008, 32'h1);
         apb(1'h1, 12'h004, md);
         apb(1'h1, 12'h00C, rl);
         apb(1'h1, 12'h008, 32'h3);
      end
   endtask
   task final_report;
      begin
         $display("checks %0d errors %0d", check_count, error_cnt);
         if (error_cnt == 0 && check_count > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask

   // ==========================================
   // main sequence
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      for (i = 0; i < 7; i = i + 1)
         rdchk({i[9:0], 2'h0}, (i == 3 || i == 4) ? 32'hFFFF : 32'h0);
      apb(1'h1, 12'h01C, 32'h0);
      chk(err, 1'h1);
      apb(1'h1, 12'h010, 32'h5);
      rdchk(12'h010, 32'hFFFF);
      apb(1'h1, 12'h008, 32'h100);
      rdchk(12'h008, 32'h0);
      $display("test registers done");
      for (i = 0; i < 3; i = i + 1) begin
         r = 2 + {$random(seed)} % 4;
         start((i == 2) ? 32'h1 : {i[27:0], 4'h0}, 32'h0, r);
         apb(1'h1, 12'h008, 32'h101);
         wpul(t0);
         u = uclk;
         wpul(t1);
         chk((t1 - t0) / 50, (r + 1) * ((i == 0) ? 8 : 16));
         chk(uclk ^ u, 1'h1);
      end
      rdchk(12'h014, 32'h1);
      chk(irq, 1'h0);
      apb(1'h1, 12'h018, 32'h1);
      wpul(t0);
      chk(irq, 1'h1);
      apb(1'h1, 12'h014, 32'h0);
      chk(irq, 1'h1);
      apb(1'h1, 12'h014, 32'h1);
      chk(irq, 1'h0);
      apb(1'h1, 12'h018, 32'h0);
      $display("test repeat and flag done");
      start(32'h13, 32'h0, r);
      apb(1'h1, 12'h008, 32'h101);
      c = npul;
      for (i = 0; i <= r; i = i + 1) begin
         chk(npul, c);
         evt <= 1'h1;
         repeat (4) @(posedge pclk);
         evt <= 1'h0;
         repeat (4) @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
      chk(npul, c + 1);
      $display("test event count done");
      start(32'h0, 32'h1, r);
      repeat (2) @(posedge pclk);
      rdchk(12'h010, r);
      u = uclk;
      apb(1'h1, 12'h008, 32'h101);
      wpul(t0);
      c = npul;
      repeat (8 * (r + 2)) @(posedge pclk);
      rdchk(12'h008, 32'h1);
      rdchk(12'h010, r);
      chk(npul, c);
      chk(uclk, u);
      $display("test one-shot done");
      start(32'h0, 32'h0, 32'h0FFF);
      apb(1'h1, 12'h008, 32'h101);
      for (i = 0; i < 4; i = i + 1) begin
         dbg <= (i == 0 || i == 2);
         slp <= (i == 1 || i == 3);
         ssc <= (i == 3) ? 4'hE : 4'h1;
         if (i == 2)
            apb(1'h1, 12'h000, 32'h100);
         repeat (8) @(posedge pclk);
         apb(1'h0, 12'h010, 32'h0);
         c = rd;
         repeat (40) @(posedge pclk);
         apb(1'h0, 12'h010, 32'h0);
         chk(rd == c, i < 2);
      end
      dbg <= 1'h0;
      slp <= 1'h0;
      $display("test debug and sleep done");
      final_report;
   end
endmodule // tb
